// [hdl/cdeu_pkg.sv]
/*
 * constants, register indices and types shared by the counter diagnostic event unit.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package cdeu_pkg;
   // channel counts and channel ids
   localparam int NUM_CH = 4;
   localparam logic [2:0] MOD_CH = 3'h4;           // pseudo channel for supply and output faults
   localparam logic [1:0] LAST_CNT_CH = 2'h3;      // counter with gate and latch events
   // process event byte bit positions
   localparam int EVB_GATE_OPEN = 0;
   localparam int EVB_GATE_CLOSE = 1;
   localparam int EVB_OVF = 2;
   localparam int EVB_CMP = 3;
   localparam int EVB_LATCH = 4;
   localparam int EVB_INTEG_END = 0;
   // record indices as read through the record read service
   localparam logic [3:0] REG_DIAG_FAULT_SUMMARY = 4'h0;
   localparam logic [3:0] REG_DIAG_MODULE_CLASS = 4'h1;
   localparam logic [3:0] REG_DIAG_INTERNAL_SUPPLY = 4'h2;
   localparam logic [3:0] REG_DIAG_INTERRUPT_LOST = 4'h3;
   localparam logic [3:0] REG_DIAG_LOST_CHANNELS = 4'h4;
   // record field positions
   localparam int REC_MOD_FAIL = 0;
   localparam int REC_INT_ERR = 1;
   localparam int REC_EXT_ERR = 2;
   localparam int REC_CHAN_ERR = 3;
   localparam int REC_EXT_SUPPLY = 4;
   localparam int REC_CHAN_INFO = 4;
   localparam int REC_INT_SUPPLY = 4;
   localparam int REC_IRQ_LOST = 6;
   localparam logic [3:0] CLASS_DIGITAL = 4'hF;
   localparam logic [3:0] CLASS_FUNCTION = 4'h8;
   // reset values
   localparam logic [31:0] RECORD_RESET = 32'h0000_0000;
   localparam logic [15:0] BASE_ADDR_DEFAULT = 16'h0000;
   localparam int QUEUE_DEPTH_DEFAULT = 4;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PROC,
      ST_DIAG
   } cdeu_state_t;
endpackage

// [hdl/cdeu_sync2.sv]
/*
 * two flip-flop synchroniser for a bundle of independent levels.
 * assumes the levels change slowly compared with clk; no bus coherency is kept.
 */
`timescale 1ns/100ps
module cdeu_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_q
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
endmodule

// [hdl/cdeu_diag_queue.sv]
/*
 * in-order queue of pending diagnostic entries.
 * assumes the owner never pops when empty; a push while full is dropped.
 */
`timescale 1ns/100ps
module cdeu_diag_queue #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head,
   output logic empty,
   output logic full
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic do_push;
   logic do_pop;

   // flags and handshake qualifiers
   assign empty = (cnt_q == '0);
   assign full = (cnt_q == (AW+1)'(DEPTH));
   assign do_push = push && !full;
   assign do_pop = pop && !empty;
   assign head = mem_q[rd_q];

   // storage
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_q[wr_q] <= push_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (do_pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule

// [hdl/cdeu_counter_diag_event_unit.sv]
/*
 * event and diagnostic interrupt sequencing for four counter / frequency channels.
 * assumes event inputs are one-cycle pulses from logic on clk, fault pins are
 * asynchronous levels, and the handler side pulses handler_done once per call.
 */
// Behaviour
// - counter mode, counters 0-2: bit 2 over/underflow, bit 3 comparison, rest zero
// - counter 3 byte 11: gate open, gate closed, flow, compare, latch; bits 7-5 zero
// - frequency mode: bit 0 of bytes 8-11 marks end of integration time
// - process interrupts only when interrupt selection is diagnostic plus process
// - diagnostic interrupts only while the global diagnostic enable is set; the unit gates only queue pushes on it, not queued or outgoing calls
// - same event recurring during its own service raises a diagnostic
// - incoming diagnostic preempts the process handler in service
// - events on other channels are buffered during diagnostic handling
// - afterwards buffered diagnostics go first in order, then process events
// - events of a channel under diagnosis are discarded until its outgoing one
// - finishing the triggering process handler calls the outgoing diagnostic
// - fault indicator on from first incoming to last outgoing diagnostic
// - every incoming or outgoing diagnostic logs cause and module address
// - latest diagnostic record stays readable with diagnostics disabled
// - four-byte record loaded into event word before diagnostic call
// - record byte 0 holds failure, internal, external, channel, supply flags
// - failure on lost irq, supply or short; internal on supply or short
// - record byte 1: module class code, bit 4 channel info present
// - record byte 2 bit 4 marks missing internal supply
// - record byte 3 bit 6 marks lost process interrupt
// - process call presents the module base address beside the event word
`timescale 1ns/100ps
module cdeu_counter_diag_event_unit
#(
   parameter logic [15:0] BASE_ADDR = cdeu_pkg::BASE_ADDR_DEFAULT,
   parameter logic [3:0] MODULE_CLASS = cdeu_pkg::CLASS_FUNCTION,
   parameter int QUEUE_DEPTH = cdeu_pkg::QUEUE_DEPTH_DEFAULT
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] chan_freq_mode,
   input wire logic irq_select_both,
   input wire logic diag_irq_enable,
   input wire logic [3:0] ovf_evt,
   input wire logic [3:0] cmp_evt,
   input wire logic [3:0] integ_end_evt,
   input wire logic gate_open_evt,
   input wire logic gate_close_evt,
   input wire logic latch_evt,
   input wire logic input_section_supply_missing,
   input wire logic output_section_supply_missing,
   input wire logic output_short,
   input wire logic handler_done,
   input wire logic rd_req,
   input wire logic [3:0] rd_index,
   output logic process_event_handler_q,
   output logic diagnostic_event_handler_q,
   output logic [31:0] event_word_q,
   output logic [15:0] base_addr_q,
   output logic system_fault_indicator_q,
   output logic log_valid_q,
   output logic log_outgoing_q,
   output logic [7:0] log_cause_q,
   output logic [15:0] log_addr_q,
   output logic rd_valid_q,
   output logic [7:0] rd_data_q
);
   import cdeu_pkg::*;

   // builds one channel's process event byte for its mode
   function automatic logic [7:0] evt_byte(input logic freq, input logic [1:0] ch,
                                           input logic ovf, input logic cmp,
                                           input logic integ);
      logic [7:0] r;
      r = 8'h00;
      if (freq) begin
         r[EVB_INTEG_END] = integ;
      end else begin
         r[EVB_OVF] = ovf;
         r[EVB_CMP] = cmp;
         if (ch == LAST_CNT_CH) begin
            r[EVB_GATE_OPEN] = gate_open_evt;
            r[EVB_GATE_CLOSE] = gate_close_evt;
            r[EVB_LATCH] = latch_evt;
         end
      end
      return r;
   endfunction

   // builds the four-byte diagnostic record from the cause and present faults
   function automatic logic [31:0] build_record(input logic lost, input logic sup_miss,
                                                input logic short_ovl);
      logic [31:0] r;
      r = RECORD_RESET;
      r[REC_MOD_FAIL] = lost | sup_miss | short_ovl;
      r[REC_INT_ERR] = sup_miss | short_ovl;
      r[REC_CHAN_ERR] = lost;
      r[11:8] = MODULE_CLASS;
      r[8 + REC_CHAN_INFO] = lost | sup_miss | short_ovl;
      r[16 + REC_INT_SUPPLY] = sup_miss;
      r[24 + REC_IRQ_LOST] = lost;
      return r;
   endfunction

   logic [2:0] fault_sync;
   logic sup_miss, fault_now, fault_seen_q, take, start_diag, push, push_lost, push_fault;
   logic fault_edge, q_pop, q_empty, q_full, svc_valid_q, svc_valid_d, susp_q, susp_d;
   logic dg_out_q, dg_out_d;
   cdeu_state_t st_q, st_d;
   logic [1:0] svc_ch_q, svc_ch_d, lost_ch, pick_ch;
   logic [7:0] svc_byte_q, svc_byte_d;
   logic [2:0] dg_ch_q, dg_ch_d;
   logic [7:0] pend_q [NUM_CH];
   logic [4:0] diag_open_q;
   logic [31:0] last_record_q, call_record;
   logic [3:0] lost_mask_q, lost, pend_any, push_data, q_head;
   logic [7:0] evb [NUM_CH];

   // fault pins come from outside the clock domain
   cdeu_sync2 #(
      .WIDTH(3)
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in({output_short, output_section_supply_missing, input_section_supply_missing}),
      .sync_q(fault_sync)
   );

   assign sup_miss = fault_sync[0] | fault_sync[1];
   assign fault_now = sup_miss | fault_sync[2];
   assign fault_edge = (fault_now != fault_seen_q);

   // per-channel event bytes, repeat detection and lowest-channel picks
   always_comb begin
      lost = 4'h0;
      pend_any = 4'h0;
      lost_ch = 2'h0;
      pick_ch = 2'h0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         evb[i] = irq_select_both ? evt_byte(chan_freq_mode[i], 2'(i), ovf_evt[i], cmp_evt[i],
                                             integ_end_evt[i]) : 8'h00;
         pend_any[i] = |pend_q[i];
         // a repeat of an event still in service, or still waiting on a channel not in service, is lost
         if (!diag_open_q[i] && svc_valid_q && svc_ch_q == 2'(i)) begin
            lost[i] = |(evb[i] & svc_byte_q);
         end else if (!diag_open_q[i]) begin
            lost[i] = |(evb[i] & pend_q[i]);
         end
         if (lost[i]) begin
            lost_ch = 2'(i);
         end
         if (pend_any[i]) begin
            pick_ch = 2'(i);
         end
      end
   end

   // diagnostic queue feed: lost events first, a fault edge waits a cycle on conflict
   assign push_lost = diag_irq_enable && (|lost);
   assign push_fault = diag_irq_enable && fault_edge && !(|lost);
   assign push = push_lost | push_fault;
   assign push_data = push_lost ? {2'b00, lost_ch} : {!fault_now, MOD_CH};

   cdeu_diag_queue #(
      .WIDTH(4),
      .DEPTH(QUEUE_DEPTH)
   ) u_queue (
      .clk(clk),
      .sys_rst(sys_rst),
      .push(push),
      .push_data(push_data),
      .pop(q_pop),
      .head(q_head),
      .empty(q_empty),
      .full(q_full)
   );

   // dispatcher: diagnostics before process events, outgoing on process completion
   always_comb begin
      st_d = st_q;
      svc_valid_d = svc_valid_q;
      svc_ch_d = svc_ch_q;
      svc_byte_d = svc_byte_q;
      susp_d = susp_q;
      dg_out_d = dg_out_q;
      dg_ch_d = dg_ch_q;
      q_pop = 1'b0;
      take = 1'b0;
      start_diag = 1'b0;
      unique case (st_q)
         ST_IDLE: begin
            if (!q_empty) begin
               q_pop = 1'b1;
            end else if (|pend_any) begin
               take = 1'b1;
            end
         end
         ST_PROC: begin
            if (handler_done) begin
               svc_valid_d = 1'b0;
               if (diag_open_q[{1'b0, svc_ch_q}]) begin
                  start_diag = 1'b1;
                  dg_out_d = 1'b1;
                  dg_ch_d = {1'b0, svc_ch_q};
                  st_d = ST_DIAG;
               end else begin
                  st_d = ST_IDLE;
               end
            end else if (!q_empty) begin
               susp_d = 1'b1;
               q_pop = 1'b1;
            end
         end
         ST_DIAG: begin
            if (handler_done) begin
               if (!q_empty) begin
                  q_pop = 1'b1;
               end else if (susp_q) begin
                  susp_d = 1'b0;
                  st_d = ST_PROC;
               end else if (|pend_any) begin
                  take = 1'b1;
               end else begin
                  st_d = ST_IDLE;
               end
            end
         end
      endcase
      if (q_pop) begin
         start_diag = 1'b1;
         dg_out_d = q_head[3];
         dg_ch_d = q_head[2:0];
         st_d = ST_DIAG;
      end
      if (take) begin
         svc_valid_d = 1'b1;
         svc_ch_d = pick_ch;
         svc_byte_d = pend_q[pick_ch];
         st_d = ST_PROC;
      end
   end

   // record for the diagnostic call being started
   assign call_record = build_record(!dg_out_d && dg_ch_d != MOD_CH, sup_miss, fault_sync[2]);

   // sequencer state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q <= ST_IDLE;
         svc_valid_q <= 1'b0;
         svc_ch_q <= 2'h0;
         svc_byte_q <= 8'h00;
         susp_q <= 1'b0;
         dg_out_q <= 1'b0;
         dg_ch_q <= 3'h0;
      end else begin
         st_q <= st_d;
         svc_valid_q <= svc_valid_d;
         svc_ch_q <= svc_ch_d;
         svc_byte_q <= svc_byte_d;
         susp_q <= susp_d;
         dg_out_q <= dg_out_d;
         dg_ch_q <= dg_ch_d;
      end
   end

   // buffered process events; a new event wins over the take that clears the byte
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_CH; i++) begin
            pend_q[i] <= 8'h00;
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (diag_open_q[i] || lost[i]) begin
               pend_q[i] <= (take && pick_ch == 2'(i)) ? 8'h00 : pend_q[i];
            end else begin
               pend_q[i] <= ((take && pick_ch == 2'(i)) ? 8'h00 : pend_q[i]) | evb[i];
            end
         end
      end
   end

   // channels under diagnosis; opening wins over closing in the same cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         diag_open_q <= 5'h00;
         fault_seen_q <= 1'b0;
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (push && !q_full && push_data[2:0] == 3'(i) && !push_data[3]) begin
               diag_open_q[i] <= 1'b1;
            end else if (st_q == ST_DIAG && handler_done && dg_out_q && dg_ch_q == 3'(i)) begin
               diag_open_q[i] <= 1'b0;
            end
         end
         if (fault_edge && !push_lost) begin
            fault_seen_q <= fault_now;
         end
      end
   end

   // latest diagnostic event, kept whether or not diagnostics are enabled
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         last_record_q <= RECORD_RESET;
         lost_mask_q <= 4'h0;
      end else if (|lost) begin
         last_record_q <= build_record(1'b1, sup_miss, fault_sync[2]);
         lost_mask_q <= lost;
      end else if (fault_edge) begin
         last_record_q <= build_record(1'b0, sup_miss, fault_sync[2]);
         lost_mask_q <= 4'h0;
      end
   end

   // handler call outputs, latched at invocation and held through the call
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         process_event_handler_q <= 1'b0;
         diagnostic_event_handler_q <= 1'b0;
         event_word_q <= 32'h0000_0000;
         base_addr_q <= BASE_ADDR_DEFAULT;
      end else begin
         process_event_handler_q <= (st_d == ST_PROC);
         diagnostic_event_handler_q <= (st_d == ST_DIAG);
         if (start_diag) begin
            event_word_q <= call_record;
            base_addr_q <= BASE_ADDR;
         end else if (st_d == ST_PROC && st_q != ST_PROC) begin
            event_word_q <= {24'h00_0000, svc_byte_d} << {svc_ch_d, 3'b000};
            base_addr_q <= BASE_ADDR;
         end
      end
   end

   // fault indicator and diagnostic buffer log
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         system_fault_indicator_q <= 1'b0;
         log_valid_q <= 1'b0;
         log_outgoing_q <= 1'b0;
         log_cause_q <= 8'h00;
         log_addr_q <= BASE_ADDR_DEFAULT;
      end else begin
         system_fault_indicator_q <= |diag_open_q;
         log_valid_q <= start_diag;
         if (start_diag) begin
            log_outgoing_q <= dg_out_d;
            log_cause_q <= call_record[7:0];
            log_addr_q <= BASE_ADDR;
         end
      end
   end

   // record read service: four record bytes plus extended lost-channel byte
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= 8'h00;
      end else begin
         rd_valid_q <= rd_req;
         if (rd_req) begin
            unique case (rd_index)
               REG_DIAG_FAULT_SUMMARY: rd_data_q <= last_record_q[7:0];
               REG_DIAG_MODULE_CLASS: rd_data_q <= last_record_q[15:8];
               REG_DIAG_INTERNAL_SUPPLY: rd_data_q <= last_record_q[23:16];
               REG_DIAG_INTERRUPT_LOST: rd_data_q <= last_record_q[31:24];
               REG_DIAG_LOST_CHANNELS: rd_data_q <= {4'h0, lost_mask_q};
               default: rd_data_q <= 8'h00;
            endcase
         end
      end
   end
endmodule

// [sim/cdeu_event_unit_sva.sv]
/*
 * port assertions and covers for the counter diagnostic event unit.
 * assumes one clock, synchronous active-high reset, bound onto the top module.
 */
`timescale 1ns/100ps
module cdeu_event_unit_sva
   import cdeu_pkg::*;
#(
   parameter logic [15:0] BASE_ADDR = 16'h0000,
   parameter logic [3:0] MODULE_CLASS = 4'h8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] chan_freq_mode,
   input wire logic diag_irq_enable,
   input wire logic rd_req,
   input wire logic process_event_handler_q,
   input wire logic diagnostic_event_handler_q,
   input wire logic [31:0] event_word_q,
   input wire logic [15:0] base_addr_q,
   input wire logic system_fault_indicator_q,
   input wire logic log_valid_q,
   input wire logic log_outgoing_q,
   input wire logic rd_valid_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // handler calls never overlap, a diagnostic call suspends the process call
   calls_exclusive_a: assert property (
      !(process_event_handler_q && diagnostic_event_handler_q))
      else $error("both handler calls active");
   diag_enable_a: assert property (
      $rose(diagnostic_event_handler_q) |-> diag_irq_enable || $past(diag_irq_enable))
      else $error("diagnostic call while disabled");
   diag_log_a: assert property (
      $rose(diagnostic_event_handler_q) |-> log_valid_q || $past(log_valid_q))
      else $error("diagnostic call without log entry");
   lamp_on_a: assert property (
      log_valid_q && !log_outgoing_q |-> ##[0:2] system_fault_indicator_q)
      else $error("fault indicator off after incoming diagnostic");
   rd_answer_a: assert property (rd_req |=> rd_valid_q)
      else $error("read not answered");
   rd_quiet_a: assert property (!rd_req |=> !rd_valid_q)
      else $error("read answer without request");
   // call data must not move while the handler runs
   call_stable_a: assert property (
      (process_event_handler_q && $past(process_event_handler_q)) ||
      (diagnostic_event_handler_q && $past(diagnostic_event_handler_q) && !log_valid_q)
      |-> $stable(event_word_q))
      else $error("event word changed during call");
   proc_reserved_a: assert property (
      process_event_handler_q |-> (event_word_q & 32'hE0E0_E0E0) == 32'h0000_0000)
      else $error("reserved event bits set");
   cnt_lane_a: assert property (
      process_event_handler_q && !chan_freq_mode[0]
      |-> event_word_q[7:4] == 4'h0 && event_word_q[1:0] == 2'h0)
      else $error("counter lane holds stray bits");
   freq_lane_a: assert property (
      process_event_handler_q && chan_freq_mode == 4'hF
      |-> (event_word_q & 32'hFEFE_FEFE) == 32'h0000_0000)
      else $error("frequency lane holds stray bits");
   diag_record_a: assert property (
      diagnostic_event_handler_q |-> (event_word_q & 32'hBFEF_E0E0) == 32'h0000_0000
      && event_word_q[11:8] == MODULE_CLASS)
      else $error("diagnostic record malformed");
   base_addr_a: assert property (
      $rose(process_event_handler_q) |=> base_addr_q == BASE_ADDR)
      else $error("base address missing");

   // main scenarios
   diag_seen_c: cover property ($rose(diagnostic_event_handler_q));
   outgoing_seen_c: cover property (log_valid_q && log_outgoing_q);
   read_seen_c: cover property (rd_valid_q);
endmodule

bind cdeu_counter_diag_event_unit cdeu_event_unit_sva #(
   .BASE_ADDR(BASE_ADDR),
   .MODULE_CLASS(MODULE_CLASS)
) cdeu_event_unit_sva_i (
   .clk(clk), .sys_rst(sys_rst), .chan_freq_mode(chan_freq_mode),
   .diag_irq_enable(diag_irq_enable), .rd_req(rd_req),
   .process_event_handler_q(process_event_handler_q),
   .diagnostic_event_handler_q(diagnostic_event_handler_q),
   .event_word_q(event_word_q), .base_addr_q(base_addr_q),
   .system_fault_indicator_q(system_fault_indicator_q), .log_valid_q(log_valid_q),
   .log_outgoing_q(log_outgoing_q), .rd_valid_q(rd_valid_q)
);

// [sim/cdeu_handler_model.sv]
/*
 * handler software model: finishes each handler call after a set latency.
 * assumes the unit drops a call within two cycles of handler_done.
 */
`timescale 1ns/100ps
module cdeu_handler_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic proc_call,
   input wire logic diag_call,
   input wire logic [7:0] latency,
   output logic handler_done
);
   logic [1:0] kind_q;
   logic [7:0] cnt_q;
   // restart the count whenever the called handler changes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         kind_q <= 2'h0;
         cnt_q <= 8'h00;
         handler_done <= 1'b0;
      end else begin
         kind_q <= {diag_call, proc_call};
         handler_done <= 1'b0;
         if ({diag_call, proc_call} != kind_q || handler_done) begin
            cnt_q <= 8'h00;
         end else if (kind_q != 2'h0) begin
            cnt_q <= cnt_q + 8'h01;
            handler_done <= (cnt_q == latency);
         end
      end
   end
endmodule

// [sim/counter_diag_event_unit_bench.sv]
/*
 * self-checking bench for the counter diagnostic event unit.
 * assumes the handler model answers calls; inputs change on rising edges.
 */
`timescale 1ns/100ps
module counter_diag_event_unit_bench;
   import cdeu_pkg::*;
   localparam logic [15:0] BASE = 16'h0120;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] chan_freq_mode = 4'h0, ovf_evt = 4'h0, cmp_evt = 4'h0, integ_end_evt = 4'h0;
   logic irq_select_both = 1'b0, diag_irq_enable = 1'b0, rd_req = 1'b0;
   logic gate_open_evt = 1'b0, gate_close_evt = 1'b0, latch_evt = 1'b0;
   logic in_sup = 1'b0, out_sup = 1'b0, out_short = 1'b0;
   logic [3:0] rd_index = 4'h0;
   logic [7:0] latency = 8'h04;
   logic handler_done, proc_q, diag_q, ind_q, log_valid_q, log_out_q, rd_valid_q;
   logic [31:0] word_q;
   logic [15:0] base_q, log_addr_q;
   logic [7:0] log_cause_q, rd_data_q;
   int miscompares = 0;
   int n_checks = 0;
   // free-running system clock
   always #5 clk = ~clk;

   cdeu_counter_diag_event_unit #(.BASE_ADDR(BASE)) cdeu_counter_diag_event_unit_i (
      .clk(clk), .sys_rst(sys_rst), .chan_freq_mode(chan_freq_mode),
      .irq_select_both(irq_select_both), .diag_irq_enable(diag_irq_enable),
      .ovf_evt(ovf_evt), .cmp_evt(cmp_evt), .integ_end_evt(integ_end_evt),
      .gate_open_evt(gate_open_evt), .gate_close_evt(gate_close_evt), .latch_evt(latch_evt),
      .input_section_supply_missing(in_sup), .output_section_supply_missing(out_sup),
      .output_short(out_short), .handler_done(handler_done), .rd_req(rd_req),
      .rd_index(rd_index), .process_event_handler_q(proc_q),
      .diagnostic_event_handler_q(diag_q), .event_word_q(word_q), .base_addr_q(base_q),
      .system_fault_indicator_q(ind_q), .log_valid_q(log_valid_q),
      .log_outgoing_q(log_out_q), .log_cause_q(log_cause_q), .log_addr_q(log_addr_q),
      .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q));
   cdeu_handler_model cdeu_handler_model_i (
      .clk(clk), .sys_rst(sys_rst), .proc_call(proc_q), .diag_call(diag_q),
      .latency(latency), .handler_done(handler_done));

   task automatic finish_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // one-cycle event pulse: 0 flow, 1 compare, 2 integration, 3 open, 4 close, 5 latch
   task automatic pulse(input int k, input int ch);
      @(posedge clk);
      case (k)
         0: ovf_evt[ch] <= 1'b1;
         1: cmp_evt[ch] <= 1'b1;
         2: integ_end_evt[ch] <= 1'b1;
         3: gate_open_evt <= 1'b1;
         4: gate_close_evt <= 1'b1;
         default: latch_evt <= 1'b1;
      endcase
      @(posedge clk);
      {ovf_evt, cmp_evt, integ_end_evt} <= 12'h000;
      {gate_open_evt, gate_close_evt, latch_evt} <= 3'h0;
      #1;
   endtask

   // wait for a new handler call of the given kind
   task automatic await(input logic diag);
      logic prev;
      logic now;
      prev = diag ? diag_q : proc_q;
      for (int i = 0; i < 300; i++) begin
         tick(1);
         now = diag ? diag_q : proc_q;
         if (now && !prev) return;
         prev = now;
      end
      miscompares++;
      $display("unexpected at %0t: call %h missing, expected 1", $time, diag);
      finish_test();
   endtask

   task automatic quiet(input int n);
      repeat (n) begin
         tick(1);
         cmp_bit(proc_q | diag_q, 1'b0);
      end
   endtask

   task automatic rd(input logic [3:0] idx, input logic [7:0] mask, input logic [7:0] exp);
      @(posedge clk);
      rd_req <= 1'b1;
      rd_index <= idx;
      @(posedge clk);
      rd_req <= 1'b0;
      #1;
      cmp_bit(rd_valid_q, 1'b1);
      cmp_word({24'h0, rd_data_q & mask}, {24'h0, exp});
   endtask

   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      pulse(0, 0);
      quiet(8);
      $display("test select mask done");
      @(posedge clk);
      irq_select_both <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         pulse(i % 2, i / 2);
         await(1'b0);
         cmp_word(word_q, 32'h1 << (8 * (i / 2) + 2 + i % 2));
      end
      cmp_word({16'h0, base_q}, {16'h0, BASE});
      for (int i = 0; i < 5; i++) begin
         pulse(i < 2 ? 3 + i : (i < 4 ? i - 2 : 5), 3);
         await(1'b0);
         cmp_word(word_q, 32'h1 << (24 + i));
      end
      $display("test counter events done");
      tick(12);
      chan_freq_mode <= 4'hF;
      for (int i = 0; i < 4; i++) begin
         pulse(2, i);
         await(1'b0);
         cmp_word(word_q, 32'h1 << (8 * i));
      end
      tick(12);
      chan_freq_mode <= 4'h0;
      latency <= 8'h1E;
      diag_irq_enable <= 1'b1;
      $display("test frequency events done");
      pulse(0, 0);
      await(1'b0);
      pulse(0, 0);
      await(1'b1);
      cmp_bit(proc_q, 1'b0);
      cmp_word(word_q & 32'hFFFF_FFF3, 32'h4000_1801);
      pulse(0, 0);
      pulse(1, 1);
      cmp_bit(ind_q, 1'b1);
      await(1'b0);
      cmp_word(word_q, 32'h0000_0004);
      await(1'b1);
      await(1'b0);
      cmp_word(word_q, 32'h0000_0800);
      tick(36);
      quiet(20);
      cmp_bit(ind_q, 1'b0);
      $display("test lost event done");
      @(posedge clk);
      diag_irq_enable <= 1'b0;
      out_sup <= 1'b1;
      quiet(10);
      rd(4'h0, 8'h03, 8'h03);
      rd(4'h2, 8'hFF, 8'h10);
      rd(4'h9, 8'hFF, 8'h00);
      @(posedge clk);
      out_sup <= 1'b0;
      tick(10);
      $display("test disabled record done");
      @(posedge clk);
      diag_irq_enable <= 1'b1;
      in_sup <= 1'b1;
      await(1'b1);
      cmp_word(word_q & 32'hFFFF_FFF3, 32'h0010_1803);
      tick(2);
      cmp_bit(ind_q, 1'b1);
      cmp_word({16'h0, log_addr_q}, {16'h0, BASE});
      tick(40);
      in_sup <= 1'b0;
      await(1'b1);
      tick(40);
      cmp_bit(ind_q, 1'b0);
      $display("test supply fault done");
      finish_test();
   end
endmodule
